// >>> core/swv_pkg.sv
// Constants, field layouts and types of the stop, wake, watchdog and voltage block
// What the document requires of this block, its firmware and its wake sources
// RL1 - Delay select bit chooses delayed or immediate resume
// RL2 - Firmware selects delay for crystal or resonator
// RL3 - Three-bit field selects the wake source
// RL4 - Codes 110/111 use NOR of port two
// RL5 - Port two outputs drop out of NOR
// RL6 - Delay bit clear skips delay; resets to one
// RL7 - Fast wake source held ten clock periods
// RL8 - Polarity bit picks high or low wake
// RL9 - Warm start bit set by STOP wake only
// RL10 - Watchdog period codes 5, 10, 20, 80 ms
// RL11 - Watchdog in halt bit; resets to one
// RL12 - Enable bit turns voltage monitoring on
// RL13 - High flag only above high threshold
// RL14 - Low flag only below low threshold
// RL15 - Low flag latches request five until cleared
// RL16 - Mask gates request five onto interrupt
// RL17 - Firmware enables interrupts before voltage detection
// RL18 - Delay counter holds execution for reset interval
package swv_pkg;

	// Register byte addresses
	localparam logic [7:0] OFS_STOP_RECOVERY = 8'h00;
	localparam logic [7:0] OFS_WATCHDOG = 8'h04;
	localparam logic [7:0] OFS_COMMAND = 8'h08;
	localparam logic [7:0] OFS_VOLTAGE = 8'h0c;
	localparam logic [7:0] OFS_IRQ_STATUS = 8'h10;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h14;

	// Interrupt status bit positions
	localparam int unsigned IRQ_WAKE_BIT = 0;
	localparam int unsigned IRQ_WDT_BIT = 1;
	localparam int unsigned IRQ_LOW_VOLT_BIT = 5;
	localparam logic [7:0] IRQ_IMPL_MASK = 8'h23;

	// Voltage control bit positions
	localparam int unsigned VOLT_EN_BIT = 0;
	localparam int unsigned VOLT_LOW_BIT = 1;
	localparam int unsigned VOLT_HIGH_BIT = 2;

	// Command register: writing one here enters STOP
	localparam int unsigned CMD_STOP_BIT = 0;

	// Wake source codes
	localparam logic [2:0] SRC_RESET_ONLY = 3'h0;
	localparam logic [2:0] SRC_RESERVED = 3'h1;
	localparam logic [2:0] SRC_CMP_ONE = 3'h2;
	localparam logic [2:0] SRC_CMP_TWO = 3'h3;
	localparam logic [2:0] SRC_REF_TWO = 3'h4;
	localparam logic [2:0] SRC_P2_SEVEN = 3'h5;
	localparam logic [2:0] SRC_NOR_LOW4 = 3'h6;
	localparam logic [2:0] SRC_NOR_ALL = 3'h7;

	typedef struct packed {
		logic warm;
		logic polarity;
		logic delay_sel;
		logic [2:0] src;
		logic [1:0] rsvd;
	} swv_stop_recovery_t;

	typedef struct packed {
		logic [4:0] rsvd;
		logic in_halt;
		logic [1:0] period;
	} swv_watchdog_t;

	// Field values after reset
	localparam swv_stop_recovery_t STOP_RECOVERY_RST = '{warm: 1'b0, polarity: 1'b0,
		delay_sel: 1'b1, src: 3'h0, rsvd: 2'h0};
	localparam swv_watchdog_t WATCHDOG_RST = '{rsvd: 5'h00, in_halt: 1'b1, period: 2'h0};
	localparam logic [7:0] IRQ_MASK_RST = 8'h00;

	typedef enum logic [1:0] {
		SWV_RUN = 2'b00,
		SWV_STOP = 2'b01,
		SWV_DELAY = 2'b10
	} swv_state_t;

	// Timing: one slow tick stands in for the internal RC time base
	localparam int unsigned CLK_MHZ = 125;
	localparam int unsigned TICK_US = 500;
	localparam int unsigned TICK_CYCLES = TICK_US * CLK_MHZ;
	localparam int unsigned T_POR_MIN_US = 2500;
	localparam int unsigned POR_TICKS = (T_POR_MIN_US + TICK_US - 1) / TICK_US;
	localparam int unsigned WDT_MS_0 = 5;
	localparam int unsigned WDT_MS_1 = 10;
	localparam int unsigned WDT_MS_2 = 20;
	localparam int unsigned WDT_MS_3 = 80;
	localparam logic [7:0] WDT_TICKS_0 = 8'(WDT_MS_0 * 1000 / TICK_US);
	localparam logic [7:0] WDT_TICKS_1 = 8'(WDT_MS_1 * 1000 / TICK_US);
	localparam logic [7:0] WDT_TICKS_2 = 8'(WDT_MS_2 * 1000 / TICK_US);
	localparam logic [7:0] WDT_TICKS_3 = 8'(WDT_MS_3 * 1000 / TICK_US);

endpackage

// >>> core/swv_tick.sv
// Slow tick divider: one-cycle enable every CYCLES clocks
`timescale 1ns/1ps
module swv_tick #(
	parameter int unsigned CYCLES = 62500
) (
	input wire logic pclk, // System clock
	input wire logic presetn, // Async reset, active low
	output logic tick // One-cycle enable pulse
);

	localparam int unsigned W = (CYCLES > 1) ? $clog2(CYCLES) : 1;
	localparam logic [W-1:0] LAST = W'(CYCLES - 1);

	logic [W-1:0] cnt_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q <= '0;
			tick <= 1'b0;
		end else if (cnt_q == LAST) begin
			cnt_q <= '0;
			tick <= 1'b1;
		end else begin
			cnt_q <= cnt_q + W'(1);
			tick <= 1'b0;
		end
	end

endmodule

// >>> core/swv_top.sv
// Stop wake-up, watchdog and supply voltage monitor with APB registers
`timescale 1ns/1ps
module swv_top #(
	parameter int unsigned TICK_CYCLES = swv_pkg::TICK_CYCLES
) (
	input wire logic pclk, // System clock, 125 MHz
	input wire logic presetn, // Power-on or external reset, active low
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB write
	input wire logic [7:0] paddr, // APB byte address
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error on unmapped address
	input wire logic cmp_one_pin, // Comparator pin one level
	input wire logic cmp_two_pin, // Comparator pin two level
	input wire logic ref_two_pin, // Reference pin two level
	input wire logic [7:0] port_two_pin, // Port two pin levels
	input wire logic [7:0] port_two_out_en, // Port two bits set as outputs
	input wire logic vcc_above_high, // Supply above high threshold
	input wire logic vcc_below_low, // Supply below low threshold
	input wire logic core_halt, // Core is in HALT
	input wire logic wdt_kick, // Core restarts the watchdog
	output logic core_run, // Core may execute
	output logic stop_mode, // Device is in STOP
	output logic wdt_reset, // Watchdog timeout pulse
	output logic irq // Interrupt request, level
);

	swv_pkg::swv_stop_recovery_t smr_q;
	swv_pkg::swv_watchdog_t wdm_q;
	swv_pkg::swv_state_t state_q;
	logic volt_en_q;
	logic high_flag_q;
	logic low_flag_q;
	logic [7:0] irq_status_q;
	logic [7:0] irq_mask_q;
	logic [2:0] delay_cnt_q;
	logic [7:0] wdt_cnt_q;
	logic [12:0] sync1_q;
	logic [12:0] sync2_q;
	logic tick;

	// Pins cross into the clock domain through two flops
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1_q <= '0;
			sync2_q <= '0;
		end else begin
			sync1_q <= {vcc_below_low, vcc_above_high, ref_two_pin, cmp_two_pin, cmp_one_pin, port_two_pin};
			sync2_q <= sync1_q;
		end
	end

	logic [7:0] p2_s;
	logic cmp_one_s;
	logic cmp_two_s;
	logic ref_two_s;
	logic vcc_high_s;
	logic vcc_low_s;
	assign p2_s = sync2_q[7:0];
	assign cmp_one_s = sync2_q[8];
	assign cmp_two_s = sync2_q[9];
	assign ref_two_s = sync2_q[10];
	assign vcc_high_s = sync2_q[11];
	assign vcc_low_s = sync2_q[12];

	swv_tick #(
		.CYCLES(TICK_CYCLES)
	) u_tick (
		.pclk(pclk),
		.presetn(presetn),
		.tick(tick)
	);

	// Level of the selected source before polarity; reset-only and reserved never wake
	function automatic logic [1:0] wake_level(input logic [2:0] src, input logic c1, input logic c2,
		input logic r2, input logic [7:0] p2);
		logic [1:0] r;
		r = 2'b00;
		if (src == swv_pkg::SRC_CMP_ONE) begin
			r = {1'b1, c1}; // [RL3]
		end else if (src == swv_pkg::SRC_CMP_TWO) begin
			r = {1'b1, c2}; // [RL3]
		end else if (src == swv_pkg::SRC_REF_TWO) begin
			r = {1'b1, r2}; // [RL3]
		end else if (src == swv_pkg::SRC_P2_SEVEN) begin
			r = {1'b1, p2[7]}; // [RL3]
		end else if (src == swv_pkg::SRC_NOR_LOW4) begin
			r = {1'b1, ~|p2[3:0]}; // [RL4]
		end else if (src == swv_pkg::SRC_NOR_ALL) begin
			r = {1'b1, ~|p2}; // [RL4]
		end
		return r;
	endfunction

	// Output bits read as zero so they never block the NOR
	logic [7:0] p2_eff;
	assign p2_eff = p2_s & ~port_two_out_en; // [RL5]

	logic [1:0] lvl;
	logic wake;
	assign lvl = wake_level(smr_q.src, cmp_one_s, cmp_two_s, ref_two_s, p2_eff);
	assign wake = lvl[1] & (smr_q.polarity ? lvl[0] : ~lvl[0]); // [RL8]

	// APB: access phase takes two cycles, pready registered
	logic acc;
	logic wr_en;
	logic rd_hit;
	assign acc = psel & penable;
	assign wr_en = acc & pwrite & pready;

	function automatic logic addr_mapped(input logic [7:0] a);
		return (a == swv_pkg::OFS_STOP_RECOVERY) || (a == swv_pkg::OFS_WATCHDOG) ||
			(a == swv_pkg::OFS_COMMAND) || (a == swv_pkg::OFS_VOLTAGE) ||
			(a == swv_pkg::OFS_IRQ_STATUS) || (a == swv_pkg::OFS_IRQ_MASK);
	endfunction

	assign rd_hit = addr_mapped(paddr);

	logic [31:0] rd_data;
	always_comb begin
		rd_data = 32'h0000_0000;
		if (paddr == swv_pkg::OFS_STOP_RECOVERY) begin
			rd_data = {24'h00_0000, smr_q};
		end else if (paddr == swv_pkg::OFS_WATCHDOG) begin
			rd_data = {24'h00_0000, wdm_q};
		end else if (paddr == swv_pkg::OFS_COMMAND) begin
			rd_data = {30'h0000_0000, state_q};
		end else if (paddr == swv_pkg::OFS_VOLTAGE) begin
			rd_data = {29'h0000_0000, high_flag_q, low_flag_q, volt_en_q};
		end else if (paddr == swv_pkg::OFS_IRQ_STATUS) begin
			rd_data = {24'h00_0000, irq_status_q};
		end else if (paddr == swv_pkg::OFS_IRQ_MASK) begin
			rd_data = {24'h00_0000, irq_mask_q};
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else begin
			pready <= acc & ~pready;
			if (acc & ~pready) begin
				pslverr <= ~rd_hit;
				prdata <= pwrite ? 32'h0000_0000 : rd_data;
			end else begin
				pslverr <= 1'b0;
			end
		end
	end

	function automatic logic wr_at(input logic [7:0] a, input logic [7:0] ofs);
		return a == ofs;
	endfunction

	// Watchdog limit for the current period code
	logic [7:0] wdt_limit;
	always_comb begin
		case (wdm_q.period) // [RL10]
			2'b00: wdt_limit = swv_pkg::WDT_TICKS_0;
			2'b01: wdt_limit = swv_pkg::WDT_TICKS_1;
			2'b10: wdt_limit = swv_pkg::WDT_TICKS_2;
			default: wdt_limit = swv_pkg::WDT_TICKS_3;
		endcase
	end

	logic wdt_active;
	logic wdt_expire;
	assign wdt_active = (state_q == swv_pkg::SWV_RUN) & (~core_halt | wdm_q.in_halt); // [RL11]
	assign wdt_expire = wdt_active & tick & (wdt_cnt_q >= wdt_limit - 8'h01);

	logic stop_req;
	logic delay_done;
	assign stop_req = wr_en & wr_at(paddr, swv_pkg::OFS_COMMAND) & pwdata[swv_pkg::CMD_STOP_BIT];
	assign delay_done = tick & (delay_cnt_q >= 3'(swv_pkg::POR_TICKS - 1));

	// Wake state machine
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= swv_pkg::SWV_RUN;
			delay_cnt_q <= 3'h0;
		end else begin
			case (state_q)
				swv_pkg::SWV_RUN: begin
					delay_cnt_q <= 3'h0;
					if (stop_req) begin
						state_q <= swv_pkg::SWV_STOP;
					end
				end
				swv_pkg::SWV_STOP: begin
					delay_cnt_q <= 3'h0;
					if (wake) begin
						// Fast wake resumes at once; a crystal needs the delay
						state_q <= smr_q.delay_sel ? swv_pkg::SWV_DELAY : swv_pkg::SWV_RUN; // [RL1] [RL6]
					end
				end
				swv_pkg::SWV_DELAY: begin
					if (delay_done) begin
						state_q <= swv_pkg::SWV_RUN; // [RL18]
					end else if (tick) begin
						delay_cnt_q <= delay_cnt_q + 3'h1; // [RL18]
					end
				end
				default: begin
					state_q <= swv_pkg::SWV_RUN;
					delay_cnt_q <= 3'h0;
				end
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			core_run <= 1'b1;
			stop_mode <= 1'b0;
		end else begin
			core_run <= (state_q == swv_pkg::SWV_RUN) & ~stop_req;
			stop_mode <= (state_q == swv_pkg::SWV_STOP) | stop_req;
		end
	end

	// Stop recovery control; warm bit is read only
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			smr_q <= swv_pkg::STOP_RECOVERY_RST; // [RL6] [RL8] [RL9]
		end else begin
			if (wr_en & wr_at(paddr, swv_pkg::OFS_STOP_RECOVERY)) begin
				smr_q.polarity <= pwdata[6];
				smr_q.delay_sel <= pwdata[5];
				smr_q.src <= pwdata[4:2];
			end
			if ((state_q == swv_pkg::SWV_STOP) & wake) begin
				smr_q.warm <= 1'b1; // [RL9]
			end else if (wdt_expire) begin
				smr_q.warm <= 1'b0; // [RL9]
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wdm_q <= swv_pkg::WATCHDOG_RST; // [RL11]
		end else if (wr_en & wr_at(paddr, swv_pkg::OFS_WATCHDOG)) begin
			wdm_q.in_halt <= pwdata[2];
			wdm_q.period <= pwdata[1:0];
		end
	end

	// Watchdog counter on the slow tick
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wdt_cnt_q <= 8'h00;
			wdt_reset <= 1'b0;
		end else begin
			wdt_reset <= wdt_expire;
			if (wdt_kick | wdt_expire) begin
				wdt_cnt_q <= 8'h00;
			end else if (wdt_active & tick) begin
				wdt_cnt_q <= wdt_cnt_q + 8'h01; // [RL10] [RL11]
			end
		end
	end

	// Voltage monitor; flags track the comparators only while enabled
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			volt_en_q <= 1'b0;
			high_flag_q <= 1'b0;
			low_flag_q <= 1'b0;
		end else begin
			if (wr_en & wr_at(paddr, swv_pkg::OFS_VOLTAGE)) begin
				volt_en_q <= pwdata[swv_pkg::VOLT_EN_BIT]; // [RL12]
			end
			high_flag_q <= volt_en_q & vcc_high_s; // [RL12] [RL13]
			low_flag_q <= volt_en_q & vcc_low_s; // [RL12] [RL14]
		end
	end

	// Sticky events; a set in the clearing cycle wins
	logic [7:0] irq_set;
	logic [7:0] irq_clr;
	always_comb begin
		irq_set = 8'h00;
		irq_set[swv_pkg::IRQ_LOW_VOLT_BIT] = volt_en_q & low_flag_q; // [RL15]
		irq_set[swv_pkg::IRQ_WAKE_BIT] = (state_q == swv_pkg::SWV_STOP) & wake;
		irq_set[swv_pkg::IRQ_WDT_BIT] = wdt_expire;
		irq_clr = 8'h00;
		if (wr_en & wr_at(paddr, swv_pkg::OFS_IRQ_STATUS)) begin
			irq_clr = pwdata[7:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_status_q <= 8'h00;
			irq_mask_q <= swv_pkg::IRQ_MASK_RST;
			irq <= 1'b0;
		end else begin
			irq_status_q <= ((irq_status_q & ~irq_clr) | irq_set) & swv_pkg::IRQ_IMPL_MASK; // [RL15]
			if (wr_en & wr_at(paddr, swv_pkg::OFS_IRQ_MASK)) begin
				irq_mask_q <= pwdata[7:0] & swv_pkg::IRQ_IMPL_MASK;
			end
			irq <= |(irq_status_q & irq_mask_q); // [RL16]
		end
	end

endmodule

// >>> tb/swv_top_sva.sv
// Port checker for the stop, wake, watchdog and voltage block
`timescale 1ns/1ps
module swv_top_sva #(
	parameter int unsigned TICK_CYCLES = 4
) (
	input wire logic pclk, // Clock
	input wire logic presetn, // Reset, active low
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB write
	input wire logic [7:0] paddr, // APB address
	input wire logic [31:0] pwdata, // APB write data
	input wire logic [31:0] prdata, // APB read data
	input wire logic pready, // APB ready
	input wire logic pslverr, // APB error
	input wire logic core_run, // Core may execute
	input wire logic stop_mode, // In STOP
	input wire logic wdt_reset // Watchdog pulse
);
	localparam int DLY_MAX = 5 * TICK_CYCLES + 8;
	logic dsel_q;
	logic wr_done;
	assign wr_done = psel && penable && pready && pwrite;
	// Delay select is only visible through bus writes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dsel_q <= 1'b1;
		end else if (wr_done && paddr == swv_pkg::OFS_STOP_RECOVERY) begin
			dsel_q <= pwdata[5];
		end
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_wake;
		$fell(stop_mode);
	endsequence
	sequence s_stop_cmd;
		wr_done && paddr == swv_pkg::OFS_COMMAND && pwdata[0] && core_run;
	endsequence
	chk_access_wait: assert property (psel && penable && !pready |=> pready)
		else $error("pready late");
	chk_ready_pulse: assert property (pready |=> !pready)
		else $error("pready held");
	chk_error_resp: assert property (pready |-> pslverr == (paddr > 8'h14 || paddr[1:0] != 2'h0))
		else $error("pslverr wrong");
	chk_read_upper: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
		else $error("upper read bits set");
	chk_stop_entry: assert property (s_stop_cmd |=> stop_mode && !core_run)
		else $error("stop not entered");
	chk_fast_resume: assert property (s_wake |-> dsel_q || core_run)
		else $error("fast wake held");
	chk_delay_hold: assert property (s_wake ##0 dsel_q |-> !core_run [*8])
		else $error("delay too short");
	chk_delay_end: assert property (s_wake ##0 dsel_q |-> ##[1:DLY_MAX] core_run)
		else $error("delay too long");
	chk_wdt_pulse: assert property (wdt_reset |=> !wdt_reset [*8])
		else $error("watchdog pulse wrong");
	chk_stop_nowdt: assert property (stop_mode && $past(stop_mode) |-> !wdt_reset)
		else $error("watchdog ran in stop");
endmodule
bind swv_top swv_top_sva #(.TICK_CYCLES(TICK_CYCLES)) swv_top_sva_i (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .core_run(core_run), .stop_mode(stop_mode), .wdt_reset(wdt_reset));

// >>> tb/swv_top_tb_top.sv
// Self-checking bench for the stop, wake, watchdog and voltage block
`timescale 1ns/1ps
module swv_top_tb_top;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [7:0] port_two_out_en = 8'h00;
	logic vcc_above_high = 1'b0;
	logic vcc_below_low = 1'b0;
	logic core_halt = 1'b0;
	logic wdt_kick = 1'b1;
	logic [2:0] wk_src = 3'h0;
	logic wk_pol = 1'b0;
	logic wk_fire = 1'b0;
	logic [31:0] prdata, rdata;
	logic [7:0] port_two_pin;
	logic pready, pslverr, rerr, cmp_one_pin, cmp_two_pin, ref_two_pin, core_run, stop_mode, wdt_reset, irq;
	int errors = 0;
	int tests_run = 0;
	int waited;
	always #4 pclk = ~pclk;
	swv_top #(.TICK_CYCLES(4)) swv_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.cmp_one_pin(cmp_one_pin), .cmp_two_pin(cmp_two_pin), .ref_two_pin(ref_two_pin),
		.port_two_pin(port_two_pin), .port_two_out_en(port_two_out_en), .vcc_above_high(vcc_above_high),
		.vcc_below_low(vcc_below_low), .core_halt(core_halt), .wdt_kick(wdt_kick), .core_run(core_run),
		.stop_mode(stop_mode), .wdt_reset(wdt_reset), .irq(irq));
	swv_wake_model swv_wake_model_i (.pclk(pclk), .src(wk_src), .pol(wk_pol), .fire(wk_fire),
		.out_en(port_two_out_en), .cmp_one_pin(cmp_one_pin), .cmp_two_pin(cmp_two_pin),
		.ref_two_pin(ref_two_pin), .port_two_pin(port_two_pin));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge pclk);
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		// No local limit: a missing answer is caught by the run watchdog
		while (pready !== 1'b1) begin
			@(posedge pclk);
		end
		rdata = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(rdata, e);
	endtask
	task automatic wait_hi(input logic sel, input int lim);
		waited = 0;
		while ((sel ? wdt_reset : core_run) !== 1'b1 && waited < lim) begin
			@(posedge pclk);
			waited++;
		end
	endtask
	task automatic fire_wake();
		wk_fire <= 1'b1;
		@(posedge pclk);
		wk_fire <= 1'b0;
	endtask
	task automatic t_reset();
		rdc(swv_pkg::OFS_STOP_RECOVERY, 32'h0000_0020);
		rdc(swv_pkg::OFS_WATCHDOG, 32'h0000_0004);
		rdc(swv_pkg::OFS_VOLTAGE, 32'h0);
		rdc(8'h18, 32'h0);
		chk(rerr, 1'b1);
	endtask
	task automatic t_wake();
		for (int c = 2; c < 8; c++) begin
			wk_src <= c[2:0];
			wk_pol <= 1'b1;
			port_two_out_en <= (c == 7) ? 8'h80 : 8'h01;
			wr(swv_pkg::OFS_STOP_RECOVERY, {25'h0, 2'b10, c[2:0], 2'b00});
			wr(swv_pkg::OFS_COMMAND, 32'h0000_0001);
			cyc(10);
			chk(stop_mode, 1'b1);
			fire_wake();
			wait_hi(1'b0, 40);
			chk(waited < 8, 1'b1);
			rdc(swv_pkg::OFS_STOP_RECOVERY, {24'h0, 3'b110, c[2:0], 2'b00});
		end
	endtask
	task automatic t_no_wake();
		for (int c = 0; c < 2; c++) begin
			wk_src <= c[2:0];
			wr(swv_pkg::OFS_STOP_RECOVERY, {25'h0, 2'b10, c[2:0], 2'b00});
			wr(swv_pkg::OFS_COMMAND, 32'h0000_0001);
			fire_wake();
			cyc(30);
			chk(stop_mode, 1'b1);
			rdc(swv_pkg::OFS_COMMAND, 32'h0000_0001);
		end
		presetn <= 1'b0;
		cyc(3);
		presetn <= 1'b1;
		cyc(1);
		rdc(swv_pkg::OFS_STOP_RECOVERY, 32'h0000_0020);
	endtask
	task automatic t_delay();
		wk_src <= swv_pkg::SRC_CMP_ONE;
		wk_pol <= 1'b0;
		wr(swv_pkg::OFS_STOP_RECOVERY, 32'h0000_0028); // Crystal clock, so delay on
		wr(swv_pkg::OFS_COMMAND, 32'h0000_0001);
		fire_wake();
		wait_hi(1'b0, 60);
		chk(waited > 16 && waited < 30, 1'b1);
	endtask
	task automatic t_volt();
		wr(swv_pkg::OFS_IRQ_STATUS, 32'h0000_00ff);
		vcc_below_low <= 1'b1;
		cyc(5);
		rdc(swv_pkg::OFS_VOLTAGE, 32'h0);
		rdc(swv_pkg::OFS_IRQ_STATUS, 32'h0);
		wr(swv_pkg::OFS_IRQ_MASK, 32'h0000_0020); // Unmask before enabling
		wr(swv_pkg::OFS_VOLTAGE, 32'h0000_0001);
		cyc(3);
		chk(irq, 1'b1);
		rdc(swv_pkg::OFS_VOLTAGE, 32'h0000_0003);
		wr(swv_pkg::OFS_IRQ_MASK, 32'h0);
		cyc(2);
		chk(irq, 1'b0);
		vcc_below_low <= 1'b0;
		cyc(5);
		rdc(swv_pkg::OFS_IRQ_STATUS, 32'h0000_0020);
		wr(swv_pkg::OFS_IRQ_STATUS, 32'h0000_0020);
		rdc(swv_pkg::OFS_IRQ_STATUS, 32'h0);
		vcc_above_high <= 1'b1;
		cyc(5);
		rdc(swv_pkg::OFS_VOLTAGE, 32'h0000_0005);
		wr(swv_pkg::OFS_VOLTAGE, 32'h0);
		cyc(3);
		rdc(swv_pkg::OFS_VOLTAGE, 32'h0);
	endtask
	task automatic t_wdt();
		int e;
		wr(swv_pkg::OFS_WATCHDOG, 32'h0);
		core_halt <= 1'b1;
		wdt_kick <= 1'b0;
		wait_hi(1'b1, 200);
		chk(waited, 200);
		wr(swv_pkg::OFS_WATCHDOG, 32'h0000_0004);
		wait_hi(1'b1, 60);
		chk(waited < 60, 1'b1);
		core_halt <= 1'b0;
		rdc(swv_pkg::OFS_STOP_RECOVERY, 32'h0000_0028);
		for (int p = 0; p < 4; p++) begin
			e = (p == 3) ? 640 : 40 << p;
			wr(swv_pkg::OFS_WATCHDOG, 32'(p));
			wait_hi(1'b1, 1400);
			@(posedge pclk);
			wait_hi(1'b1, 1400);
			chk(waited + 1 > e - 4 && waited + 1 < e + 4, 1'b1);
		end
		// Shortest period, no kick: STOP must freeze the count
		wr(swv_pkg::OFS_WATCHDOG, 32'h0000_0004);
		wr(swv_pkg::OFS_COMMAND, 32'h0000_0001);
		wait_hi(1'b1, 100);
		chk(waited, 100);
		chk(stop_mode, 1'b1);
	endtask
	task automatic summarize();
		$display("errors=%0d tests_run=%0d", errors, tests_run);
		if (errors == 0 && tests_run > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	initial begin
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_reset();
		t_wake();
		t_no_wake();
		t_delay();
		t_volt();
		t_wdt();
		summarize();
	end
	// Whole run is a few thousand cycles
	initial begin
		repeat (20000) @(posedge pclk);
		errors++;
		summarize();
	end
endmodule

// >>> tb/swv_wake_model.sv
// Model of the outside world driving the wake pins
`timescale 1ns/1ps
module swv_wake_model (
	input wire logic pclk, // Clock
	input wire logic [2:0] src, // Source to activate
	input wire logic pol, // Active level
	input wire logic fire, // Start one wake pulse
	input wire logic [7:0] out_en, // Port two output bits
	output logic cmp_one_pin, // Comparator pin one
	output logic cmp_two_pin, // Comparator pin two
	output logic ref_two_pin, // Reference pin two
	output logic [7:0] port_two_pin // Port two pins
);
	logic [3:0] cnt_q = 4'h0;
	logic act;
	logic any;
	// Twelve cycles, beyond the ten-period minimum
	always_ff @(posedge pclk) begin
		cnt_q <= fire ? 4'hc : cnt_q - {3'h0, act};
	end
	assign act = cnt_q != 4'h0;
	// Reset-only and reserved codes see both comparator pins and reference pin two at once
	assign any = act && src < swv_pkg::SRC_CMP_ONE;
	assign cmp_one_pin = ((act && src == swv_pkg::SRC_CMP_ONE) || any) ? pol : !pol;
	assign cmp_two_pin = ((act && src == swv_pkg::SRC_CMP_TWO) || any) ? pol : !pol;
	assign ref_two_pin = ((act && src == swv_pkg::SRC_REF_TWO) || any) ? pol : !pol;
	// Output bits read high, yet must not block the NOR
	assign port_two_pin = !act ? {!pol, 7'h7f} : (src == swv_pkg::SRC_P2_SEVEN) ? {pol, 7'h7f} : out_en;
endmodule
